// >>> rtl/sto_pkg.sv
// shared constants and types for the torque-off and dataset-select block
package sto_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PARAM_W = 16;
  localparam int NUM_SETS = 4;
  localparam int NUM_PARAMS = 4;
  localparam int SET_W = 2;

  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DSET = 8'h08;
  localparam logic [7:0] OFS_PARAM_BASE = 8'h40;
  localparam logic [1:0] PARAM_WIN_TAG = 2'h1;

  // control register fields and register reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_ACLR_BIT = 1;
  localparam int CTRL_SWSEL_BIT = 2;
  localparam int CTRL_IODIR_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] DSET_RESET = 2'h0;
  localparam logic [15:0] PARAM_RESET = 16'h0000;

  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int STOP_LIMIT_MS = 10;
  localparam int DISCORD_WAIT_S = 5;
  localparam int STOP_LIMIT_CYCLES = STOP_LIMIT_MS * (CLK_HZ / 1000);
  localparam int DISCORD_CYCLES = DISCORD_WAIT_S * CLK_HZ;
  localparam int TMR_W = 32;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_STANDBY = 3'b010,
    ST_TORQUE_OFF = 3'b100
  } stop_state_t;

  typedef logic [NUM_PARAMS-1:0][PARAM_W-1:0] param_set_t;

  typedef struct packed {
    logic [1:0] active_set;
    logic input_b;
    logic input_a;
    logic running;
    logic alarm;
    logic discord_alarm;
    logic standby;
    logic torque_off;
  } status_t;
endpackage : sto_pkg

// >>> rtl/sync2.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sync2

// >>> rtl/wait_timer.sv
// wait timer that flags expiry after a set number of cycles while enabled
`timescale 1ns/1ns
module wait_timer #(
  parameter int LIMIT = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic expired
);
  logic [sto_pkg::TMR_W-1:0] count_q;
  localparam logic [sto_pkg::TMR_W-1:0] LAST = sto_pkg::TMR_W'(LIMIT - 1);

  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      count_q <= '0;
    end else if (count_q != LAST) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign expired = run && (count_q == LAST);
endmodule : wait_timer

// >>> rtl/sto_supervisor.sv
// torque-off supervision and motor dataset selection with Avalon-MM registers
`timescale 1ns/1ns
module sto_supervisor #(
  parameter int DISCORD_CYCLES = sto_pkg::DISCORD_CYCLES,
  parameter int STOP_LIMIT_CYCLES = sto_pkg::STOP_LIMIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stop_input_a,
  input wire logic stop_input_b,
  input wire logic internal_fault,
  input wire logic dataset_sel_in,
  input wire logic cfg_io_in,
  output logic cfg_io_out,
  output logic cfg_io_oe_n,
  output logic pwm_enable,
  output logic [1:0] gate_enable,
  output logic alarm_relay,
  output logic run_output,
  output logic [1:0] active_dataset,
  output sto_pkg::param_set_t active_params
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [4:0] pins_s;
  logic sa_s, sb_s, fault_s, sel1_s, sel2_s;

  sync2 #(.W(5)) pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({cfg_io_in, dataset_sel_in, internal_fault, stop_input_b, stop_input_a}),
    .sync_out(pins_s)
  );

  assign sa_s = pins_s[0];
  assign sb_s = pins_s[1];
  assign fault_s = pins_s[2];
  assign sel1_s = pins_s[3];
  assign sel2_s = pins_s[4];

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [3:0] ctrl_q;
  logic [1:0] dset_q;
  logic [15:0] param_mem [0:15];
  logic discord_alarm_q;
  sto_pkg::stop_state_t state_q, state_d;
  logic access, wr_en, rd_en, param_hit;
  logic [31:0] rdata_d;
  sto_pkg::status_t status;

  assign access = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_en = access && avs_write;
  assign rd_en = access && avs_read;
  assign param_hit = (avs_address[7:6] == sto_pkg::PARAM_WIN_TAG) && (avs_address[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // torque-off state machine
  always_comb begin
    if (!sa_s && !sb_s) begin
      state_d = sto_pkg::ST_TORQUE_OFF;
    end else if (sa_s && sb_s) begin
      state_d = sto_pkg::ST_NORMAL;
    end else begin
      state_d = sto_pkg::ST_STANDBY;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= sto_pkg::ST_TORQUE_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  logic discord_expired;

  wait_timer #(.LIMIT(DISCORD_CYCLES)) discord_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(state_q == sto_pkg::ST_STANDBY),
    .expired(discord_expired)
  );

  logic aclr_wr;
  assign aclr_wr = wr_en && (avs_address == sto_pkg::OFS_CTRL) && avs_byteenable[0]
    && avs_writedata[sto_pkg::CTRL_ACLR_BIT];

  // a timeout in the same cycle beats a software clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      discord_alarm_q <= 1'b0;
    end else if (discord_expired) begin
      discord_alarm_q <= 1'b1;
    end else if (aclr_wr) begin
      discord_alarm_q <= 1'b0;
    end
  end

  logic alarm_any, stop_now, run_d;
  assign alarm_any = discord_alarm_q || fault_s;
  assign stop_now = (state_d == sto_pkg::ST_TORQUE_OFF) || alarm_any;
  assign run_d = ctrl_q[sto_pkg::CTRL_RUN_BIT] && !stop_now;

  ////////////////////////////////////////////////////////////////////////////
  // power stage outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_enable <= 1'b0;
      gate_enable <= 2'b00;
      alarm_relay <= 1'b0;
      run_output <= 1'b0;
    end else begin
      pwm_enable <= !stop_now;
      gate_enable <= {2{!stop_now}};
      alarm_relay <= alarm_any;
      run_output <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dataset selection and parameter store
  logic [1:0] set_d;
  assign set_d = ctrl_q[sto_pkg::CTRL_SWSEL_BIT] ? dset_q
    : {(ctrl_q[sto_pkg::CTRL_IODIR_BIT] ? 1'b0 : sel2_s), sel1_s};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_dataset <= sto_pkg::DSET_RESET;
      active_params <= '0;
    end else begin
      active_dataset <= set_d;
      for (int i = 0; i < sto_pkg::NUM_PARAMS; i++) begin
        active_params[i] <= param_mem[{set_d, i[1:0]}];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        param_mem[i] <= sto_pkg::PARAM_RESET;
      end
    end else if (wr_en && param_hit) begin
      if (avs_byteenable[0]) begin
        param_mem[avs_address[5:2]][7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        param_mem[avs_address[5:2]][15:8] <= avs_writedata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configurable i/o terminal
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_io_oe_n <= 1'b1;
      cfg_io_out <= 1'b0;
    end else begin
      cfg_io_oe_n <= !ctrl_q[sto_pkg::CTRL_IODIR_BIT];
      cfg_io_out <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= sto_pkg::CTRL_RESET;
      dset_q <= sto_pkg::DSET_RESET;
    end else if (wr_en && avs_byteenable[0]) begin
      if (avs_address == sto_pkg::OFS_CTRL) begin
        ctrl_q <= {avs_writedata[3:2], 1'b0, avs_writedata[0]};
      end
      if (avs_address == sto_pkg::OFS_DSET) begin
        dset_q <= avs_writedata[1:0];
      end
    end
  end

  always_comb begin
    status = '0;
    status.torque_off = !pwm_enable;
    status.standby = (state_q == sto_pkg::ST_STANDBY);
    status.discord_alarm = discord_alarm_q;
    status.alarm = alarm_relay;
    status.running = run_output;
    status.input_a = sa_s;
    status.input_b = sb_s;
    status.active_set = active_dataset;
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (avs_address == sto_pkg::OFS_CTRL) begin
      rdata_d = {28'h0, ctrl_q};
    end else if (avs_address == sto_pkg::OFS_STATUS) begin
      rdata_d = {23'h0, status};
    end else if (avs_address == sto_pkg::OFS_DSET) begin
      rdata_d = {30'h0, dset_q};
    end else if (param_hit) begin
      rdata_d = {16'h0, param_mem[avs_address[5:2]]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [31:0] stop_wait_q;
  always_ff @(posedge clk) begin
    if (sys_rst || pwm_enable == 1'b0 || sa_s || sb_s) begin
      stop_wait_q <= '0;
    end else begin
      stop_wait_q <= stop_wait_q + 1'b1;
    end
  end

  stop_limit_a: assert property (stop_wait_q < 32'(STOP_LIMIT_CYCLES))
    else $error("torque off too slow");
  both_low_stop_a: assert property (!sa_s && !sb_s |=> !pwm_enable && gate_enable == 2'b00)
    else $error("pwm not stopped with both inputs low");
  discord_alarm_a: assert property (discord_expired |=> discord_alarm_q ##1 alarm_relay)
    else $error("discord timeout not alarmed");
  standby_run_a: assert property (sa_s != sb_s && !alarm_any ##1 sa_s != sb_s
    |-> state_q == sto_pkg::ST_STANDBY)
    else $error("standby not entered");
  normal_run_a: assert property (sa_s && sb_s && !alarm_any |=> pwm_enable)
    else $error("pwm held off with inputs high");
  fault_stop_a: assert property (fault_s |=> !pwm_enable && gate_enable == 2'b00)
    else $error("internal alarm did not stop");
  dataset_pick_a: assert property (!ctrl_q[sto_pkg::CTRL_SWSEL_BIT]
    && !ctrl_q[sto_pkg::CTRL_IODIR_BIT] |=> active_dataset == $past({sel2_s, sel1_s}))
    else $error("dataset mismatch");
  param_src_a: assert property (##1 active_params[0] == $past(param_mem[{set_d, 2'h0}]))
    else $error("parameter from wrong dataset");
  run_out_a: assert property (run_output |-> pwm_enable && $past(ctrl_q[0]))
    else $error("run output without running");
  relay_alarm_a: assert property (alarm_any |=> alarm_relay)
    else $error("relay not following alarm");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  alarm_hold_a: assert property (discord_alarm_q && !aclr_wr |=> discord_alarm_q)
    else $error("discord alarm dropped");
  expiry_wins_a: assert property (discord_expired && aclr_wr |=> discord_alarm_q)
    else $error("clear beat the timeout");
  relay_clear_a: assert property (!alarm_any |=> !alarm_relay)
    else $error("relay without alarm");
  run_stop_a: assert property (stop_now |=> !run_output && !pwm_enable)
    else $error("running through a stop");
  gate_pair_a: assert property (gate_enable == {2{pwm_enable}})
    else $error("gate enables disagree with pwm");
  sw_set_a: assert property (ctrl_q[sto_pkg::CTRL_SWSEL_BIT]
    |=> active_dataset == $past(dset_q))
    else $error("software dataset not applied");
  io_dir_a: assert property (ctrl_q[sto_pkg::CTRL_IODIR_BIT] |=> !cfg_io_oe_n)
    else $error("terminal not driven as output");
  bus_rest_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");

  torque_off_c: cover property (!sa_s && !sb_s ##1 !pwm_enable);
  discord_c: cover property (discord_expired);
  set3_c: cover property (active_dataset == 2'h3);
  running_c: cover property (run_output);
  alarm_clear_c: cover property (discord_alarm_q ##1 !discord_alarm_q);
endmodule : sto_supervisor

// >>> testbench/safety_partner.sv
// pin model of the external safety circuit and machine controller
`timescale 1ns/1ns
module safety_partner (
  input wire logic clk,
  input wire logic [1:0] stop_req,
  input wire logic fault_req,
  input wire logic [1:0] sel_req,
  input wire logic io_out,
  input wire logic io_oe_n,
  output logic stop_a,
  output logic stop_b,
  output logic fault,
  output logic sel_lo,
  output logic io_in
);
  logic io_drv_q;
  initial begin
    stop_a = 1'b1;
    stop_b = 1'b1;
    fault = 1'b0;
    sel_lo = 1'b0;
    io_drv_q = 1'b0;
  end
  always @(posedge clk) begin
    stop_a <= stop_req[0];
    stop_b <= stop_req[1];
    fault <= fault_req;
    sel_lo <= sel_req[0];
    // one select code puts one motor on the power stage
    io_drv_q <= sel_req[1];
  end
  // terminal level from whichever side drives it
  assign io_in = io_oe_n ? io_drv_q : io_out;
endmodule : safety_partner

// >>> testbench/safe_torque_off_and_dataset_select_test.sv
// self-checking bench for the torque-off supervisor
`timescale 1ns/1ns
module safe_torque_off_and_dataset_select_test;
  logic clk = 1'b0;
  logic sys_rst;
  logic [7:0] adr;
  logic rd, wr;
  logic [31:0] wd, rv;
  logic [3:0] be;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] stop_q, sel_q;
  logic flt;
  logic s_a, s_b, f_p, sel_p, io_in, io_out, io_oe_n;
  logic pwm, relay, run_o;
  logic [1:0] gate, ads;
  sto_pkg::param_set_t aps;
  int error_cnt = 0;
  int check_count = 0;
  int mp[$];
  logic [63:0] ep;
  logic [31:0] v;
  always #5 clk = ~clk;
  sto_supervisor #(.DISCORD_CYCLES(20), .STOP_LIMIT_CYCLES(100)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .stop_input_a(s_a), .stop_input_b(s_b), .internal_fault(f_p),
    .dataset_sel_in(sel_p), .cfg_io_in(io_in), .cfg_io_out(io_out),
    .cfg_io_oe_n(io_oe_n), .pwm_enable(pwm), .gate_enable(gate),
    .alarm_relay(relay), .run_output(run_o), .active_dataset(ads),
    .active_params(aps));
  safety_partner u_far (
    .clk(clk), .stop_req(stop_q), .fault_req(flt), .sel_req(sel_q),
    .io_out(io_out), .io_oe_n(io_oe_n), .stop_a(s_a), .stop_b(s_b),
    .fault(f_p), .sel_lo(sel_p), .io_in(io_in));
  ////////////////////////////////////////
  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      $display("[FAIL] bus wait exp 0 got %b", avs_waitrequest);
    end
    rv = avs_readdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle
  ////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    sys_rst = 1'b1;
    adr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    be = 4'hF;
    stop_q = 2'b11;
    sel_q = 2'h0;
    flt = 1'b0;
    void'($urandom(32'hC8C7));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 64'h0, rv);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 64'h0, rv);
    bus(1'b1, 8'h00, 32'h1);
    settle();
    chk("run out", 64'h1, run_o);
    chk("drive on", 64'h7, {pwm, gate});
    stop_q <= 2'b00;
    settle();
    chk("both low", 64'h0, {pwm, gate});
    chk("run stop", 64'h0, run_o);
    stop_q <= 2'b11;
    settle();
    bus(1'b1, 8'h00, 32'h1);
    stop_q <= 2'b10;
    settle();
    chk("standby drive", 64'h7, {pwm, gate});
    bus(1'b0, 8'h04, 32'h0);
    chk("standby flag", 64'h1, rv[1]);
    repeat (8) @(posedge clk);
    chk("early alarm", 64'h0, relay);
    repeat (20) @(posedge clk);
    chk("discord relay", 64'h1, relay);
    chk("alarm stop", 64'h0, {pwm, gate});
    bus(1'b1, 8'h00, 32'h3);
    chk("clear refused", 64'h1, relay);
    stop_q <= 2'b11;
    settle();
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h00, 32'h1);
    settle();
    chk("alarm cleared", 64'h0, relay);
    chk("restart", 64'h7, {pwm, gate});
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl aclr", 64'h1, rv);
    flt <= 1'b1;
    settle();
    chk("fault relay", 64'h1, relay);
    chk("fault stop", 64'h0, {pwm, gate});
    flt <= 1'b0;
    settle();
    chk("fault gone", 64'h0, relay);
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      mp.push_back(int'(v[15:0]));
      bus(1'b1, 8'h40 + 8'(i * 4), v);
    end
    for (int s = 0; s < 4; s++) begin
      sel_q <= 2'(s);
      settle();
      chk("dataset", 64'(s), ads);
      for (int p = 0; p < 4; p++) ep[16*p+:16] = 16'(mp[s*4+p]);
      chk("params", ep, aps);
      bus(1'b0, 8'h04, 32'h0);
      chk("status set", 64'(s), rv[8:7]);
    end
    bus(1'b0, 8'h54, 32'h0);
    chk("param read", 64'(mp[5]), rv);
    bus(1'b1, 8'h00, 32'h9);
    settle();
    chk("io drive", 64'h0, io_oe_n);
    chk("io run", 64'h1, io_out);
    chk("io sel", 64'h1, ads);
    v = $urandom;
    bus(1'b1, 8'h08, v);
    bus(1'b1, 8'h00, 32'h5);
    settle();
    chk("sw set", 64'(v[1:0]), ads);
    for (int p = 0; p < 4; p++) ep[16*p+:16] = 16'(mp[v[1:0]*4+p]);
    chk("sw params", ep, aps);
    bus(1'b0, 8'h08, 32'h0);
    chk("dset read", 64'(v[1:0]), rv);
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl read", 64'h5, rv);
    end_sim();
  end
endmodule : safe_torque_off_and_dataset_select_test
